// ===== hw/dwp_addr_cmp.sv
// masked address comparator, one per watchpoint
`timescale 1ns/10ps
module dwp_addr_cmp
    import dwp_pkg::*;
#(
    parameter int ADDR_W = 32,
    parameter int MASK_W = 5
) (
    // reference and mask
    input wire logic [ADDR_W-1:0] ref_addr,
    input wire logic [MASK_W-1:0] mask_cnt,
    // observed address
    input wire logic [ADDR_W-1:0] addr,
    input wire logic fetch,
    // result
    output logic hit
);

    logic [ADDR_W-1:0] care;

    genvar gi;
    generate
        for (gi = 0; gi < ADDR_W; gi++) begin : g_care
            if (gi == 0) begin : g_bit0
                // fetches are halfword aligned, so bit0 is dropped then
                assign care[gi] = (mask_cnt == '0) ? ~fetch : 1'b0;
            end else begin : g_bitn
                assign care[gi] = (ADDR_W'(gi) >= ADDR_W'(mask_cnt));
            end
        end
    endgenerate

    // same-cycle compare of the transfer
    assign hit = (((ref_addr ^ addr) & care) == '0);

endmodule // dwp_addr_cmp

// ===== hw/dwp_consts.svh
// constants for the dual watchpoint comparator: offsets, fields, reset values
// Notes on behaviour
// - capability register is read-only, writes ignored
// - top nibble reports exactly two comparators
// - low 28 bits fixed, extra features disabled
// - capability bits 27 to 24 read one
// - capability bits 22 to 0 read zero
// - reference register i at 0x20 plus 16i
// - mask register i at 0x24 plus 16i
// - five-bit mask count, upper bits zero
// - mask zero: all bits, fetch ignores bit0
// - mask x ignores address bits x-1 to 0
// - written mask counts above 24 saturate to 24
// - match flag set when function occurred
// - reading function register zero clears match flag
// - bit 8 selects data or address compare
// - comparator zero data or address, one address only
// - size field: byte, halfword, word, 11 reserved
// - linked comparator field limited to zero or one
`ifndef DWP_CONSTS_SVH
`define DWP_CONSTS_SVH

// register byte offsets
`define DWP_OFS_CAP 12'h000
`define DWP_OFS_COMP_BASE 12'h020
`define DWP_OFS_MASK_BASE 12'h024
`define DWP_OFS_FCT_BASE 12'h028
`define DWP_OFS_STRIDE 12'h010

// capability value
`define DWP_CAP_COMPARATOR_COUNT 4'h2
`define DWP_CAP_CONFIG 28'hF00_0000

// mask field
`define DWP_MASK_W 5
`define DWP_MASK_MAX 5'h18

// function register fields
`define DWP_FCT_MATCH_BIT 24
`define DWP_FCT_LINK_LSB 12
`define DWP_FCT_SIZE_LSB 10
`define DWP_FCT_DM_BIT 8
`define DWP_FCT_FUNC_LSB 0

// reset values
`define DWP_RST_COMP 32'h0000_0000
`define DWP_RST_MASK 5'h00
`define DWP_RST_FUNC 4'h0

`endif

// ===== hw/dwp_pkg.sv
// types shared by the dual watchpoint comparator
package dwp_pkg;

    typedef enum logic [1:0] {
        DWP_SIZE_BYTE = 2'b00,
        DWP_SIZE_HALF = 2'b01,
        DWP_SIZE_WORD = 2'b10,
        DWP_SIZE_RSVD = 2'b11
    } dwp_size_e;

    typedef enum logic {
        DWP_BUS_IDLE = 1'b0,
        DWP_BUS_ACK = 1'b1
    } dwp_bus_state_e;

    // one observed core bus transfer
    typedef struct packed {
        logic valid;
        logic fetch;
        dwp_size_e size;
        logic [31:0] addr;
        logic [31:0] data;
    } dwp_watch_s;

    // comparator zero control fields
    typedef struct packed {
        logic link;
        dwp_size_e size;
        logic data_match;
        logic [3:0] func;
    } dwp_fct0_s;

endpackage

// ===== hw/dwp_top.sv
// dual watchpoint comparator with classic wishbone register slave
`timescale 1ns/10ps
`include "dwp_consts.svh"
module dwp_top
    import dwp_pkg::*;
#(
    parameter int ADR_W = 12,
    parameter int NUM_CMP = 2
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // watched core bus
    input wire dwp_watch_s watch_i,
    // match pulses per comparator
    output logic [NUM_CMP-1:0] match_o
);

    localparam logic [ADR_W-1:0] OFS_CAP = ADR_W'(`DWP_OFS_CAP);
    localparam logic [ADR_W-1:0] OFS_COMP0 = ADR_W'(`DWP_OFS_COMP_BASE);
    localparam logic [ADR_W-1:0] OFS_MASK0 = ADR_W'(`DWP_OFS_MASK_BASE);
    localparam logic [ADR_W-1:0] OFS_FCT0 = ADR_W'(`DWP_OFS_FCT_BASE);
    localparam logic [ADR_W-1:0] OFS_COMP1 = ADR_W'(`DWP_OFS_COMP_BASE + `DWP_OFS_STRIDE);
    localparam logic [ADR_W-1:0] OFS_MASK1 = ADR_W'(`DWP_OFS_MASK_BASE + `DWP_OFS_STRIDE);
    localparam logic [ADR_W-1:0] OFS_FCT1 = ADR_W'(`DWP_OFS_FCT_BASE + `DWP_OFS_STRIDE);
    localparam logic [31:0] CAP_VALUE = {`DWP_CAP_COMPARATOR_COUNT, `DWP_CAP_CONFIG};

    // bus state
    dwp_bus_state_e bus_state_r;
    dwp_bus_state_e bus_state_nxt;
    logic req_take;
    logic wr_take;
    logic rd_take;
    logic [31:0] rd_nxt;

    // programmable state
    logic [31:0] comp_r [NUM_CMP];
    logic [`DWP_MASK_W-1:0] mask_r [NUM_CMP];
    dwp_fct0_s fct0_r;
    logic [3:0] func1_r;
    logic [NUM_CMP-1:0] flag_r;

    // compare results
    logic [NUM_CMP-1:0] addr_hit;
    logic data_hit;
    logic [NUM_CMP-1:0] event_now;
    logic [`DWP_MASK_W-1:0] mask_wr;

    // merges a write under byte enables
    function automatic logic [31:0] merge_bytes(
        input logic [31:0] old_val,
        input logic [31:0] new_val,
        input logic [3:0] sel
    );
        logic [31:0] res;
        res = old_val;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                res[8*b +: 8] = new_val[8*b +: 8];
            end
        end
        return res;
    endfunction

    // ------------------------------------------------------------
    // wishbone handshake: ack one cycle after the request is seen
    // ------------------------------------------------------------
    assign req_take = wb_cyc_i && wb_stb_i && (bus_state_r == DWP_BUS_IDLE);
    assign wr_take = req_take && wb_we_i;
    assign rd_take = req_take && !wb_we_i;

    always_comb begin
        bus_state_nxt = bus_state_r;
        case (bus_state_r)
            DWP_BUS_IDLE: begin
                if (wb_cyc_i && wb_stb_i) begin
                    bus_state_nxt = DWP_BUS_ACK;
                end
            end
            DWP_BUS_ACK: begin
                bus_state_nxt = DWP_BUS_IDLE;
            end
            default: begin
                bus_state_nxt = DWP_BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            bus_state_r <= DWP_BUS_IDLE;
            wb_ack_o <= 1'b0;
        end else begin
            bus_state_r <= bus_state_nxt;
            wb_ack_o <= (bus_state_nxt == DWP_BUS_ACK);
        end
    end

    // ------------------------------------------------------------
    // read mux; unmapped offsets read zero
    // ------------------------------------------------------------
    always_comb begin
        rd_nxt = 32'h0000_0000;
        if (wb_adr_i == OFS_CAP) begin
            rd_nxt = CAP_VALUE;
        end else if (wb_adr_i == OFS_COMP0) begin
            rd_nxt = comp_r[0];
        end else if (wb_adr_i == OFS_MASK0) begin
            rd_nxt[`DWP_MASK_W-1:0] = mask_r[0];
        end else if (wb_adr_i == OFS_FCT0) begin
            rd_nxt[`DWP_FCT_MATCH_BIT] = flag_r[0];
            rd_nxt[`DWP_FCT_LINK_LSB] = fct0_r.link;
            rd_nxt[`DWP_FCT_SIZE_LSB +: 2] = fct0_r.size;
            rd_nxt[`DWP_FCT_DM_BIT] = fct0_r.data_match;
            rd_nxt[`DWP_FCT_FUNC_LSB +: 4] = fct0_r.func;
        end else if (wb_adr_i == OFS_COMP1) begin
            rd_nxt = comp_r[1];
        end else if (wb_adr_i == OFS_MASK1) begin
            rd_nxt[`DWP_MASK_W-1:0] = mask_r[1];
        end else if (wb_adr_i == OFS_FCT1) begin
            rd_nxt[`DWP_FCT_MATCH_BIT] = flag_r[1];
            rd_nxt[`DWP_FCT_FUNC_LSB +: 4] = func1_r;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (rd_take) begin
            wb_dat_o <= rd_nxt;
        end else if (bus_state_r == DWP_BUS_ACK) begin
            wb_dat_o <= 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------
    // reference registers; capability offset has no storage
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            comp_r[0] <= `DWP_RST_COMP;
            comp_r[1] <= `DWP_RST_COMP;
        end else if (wr_take) begin
            if (wb_adr_i == OFS_COMP0) begin
                comp_r[0] <= merge_bytes(comp_r[0], wb_dat_i, wb_sel_i);
            end else if (wb_adr_i == OFS_COMP1) begin
                comp_r[1] <= merge_bytes(comp_r[1], wb_dat_i, wb_sel_i);
            end
        end
    end

    // ------------------------------------------------------------
    // mask registers with saturation
    // ------------------------------------------------------------
    assign mask_wr = (wb_dat_i[`DWP_MASK_W-1:0] > `DWP_MASK_MAX) ?
        `DWP_MASK_MAX : wb_dat_i[`DWP_MASK_W-1:0];

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            mask_r[0] <= `DWP_RST_MASK;
            mask_r[1] <= `DWP_RST_MASK;
        end else if (wr_take && wb_sel_i[0]) begin
            if (wb_adr_i == OFS_MASK0) begin
                mask_r[0] <= mask_wr;
            end else if (wb_adr_i == OFS_MASK1) begin
                mask_r[1] <= mask_wr;
            end
        end
    end

    // ------------------------------------------------------------
    // function registers
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            fct0_r <= '{link: 1'b0, size: DWP_SIZE_BYTE, data_match: 1'b0,
                func: `DWP_RST_FUNC};
            func1_r <= `DWP_RST_FUNC;
        end else if (wr_take) begin
            if (wb_adr_i == OFS_FCT0) begin
                if (wb_sel_i[0]) begin
                    fct0_r.func <= wb_dat_i[`DWP_FCT_FUNC_LSB +: 4];
                end
                if (wb_sel_i[1]) begin
                    fct0_r.data_match <= wb_dat_i[`DWP_FCT_DM_BIT];
                    fct0_r.size <= dwp_size_e'(wb_dat_i[`DWP_FCT_SIZE_LSB +: 2]);
                    // only comparator indices zero and one exist
                    fct0_r.link <= wb_dat_i[`DWP_FCT_LINK_LSB];
                end
            end else if (wb_adr_i == OFS_FCT1) begin
                if (wb_sel_i[0]) begin
                    func1_r <= wb_dat_i[`DWP_FCT_FUNC_LSB +: 4];
                end
            end
        end
    end

    // ------------------------------------------------------------
    // comparators
    // ------------------------------------------------------------
    genvar ci;
    generate
        for (ci = 0; ci < NUM_CMP; ci++) begin : g_cmp
            dwp_addr_cmp #(
                .ADDR_W(32),
                .MASK_W(`DWP_MASK_W)
            ) u_cmp (
                .ref_addr(comp_r[ci]),
                .mask_cnt(mask_r[ci]),
                .addr(watch_i.addr),
                .fetch(watch_i.fetch),
                .hit(addr_hit[ci])
            );
        end
    endgenerate

    // data compare on comparator zero; byte and halfword sizes compare only the low lane of reference and data, word compares all 32 bits
    always_comb begin
        data_hit = 1'b0;
        case (fct0_r.size)
            DWP_SIZE_BYTE: begin
                data_hit = (watch_i.size == DWP_SIZE_BYTE) &&
                    (watch_i.data[7:0] == comp_r[0][7:0]);
            end
            DWP_SIZE_HALF: begin
                data_hit = (watch_i.size == DWP_SIZE_HALF) &&
                    (watch_i.data[15:0] == comp_r[0][15:0]);
            end
            DWP_SIZE_WORD: begin
                data_hit = (watch_i.size == DWP_SIZE_WORD) &&
                    (watch_i.data == comp_r[0]);
            end
            default: begin
                data_hit = 1'b0;
            end
        endcase
    end

    // comparator zero: data mode needs the comparator one address hit only when link is set
    always_comb begin
        event_now = '0;
        if (watch_i.valid && (fct0_r.func != 4'h0)) begin
            if (fct0_r.data_match) begin
                event_now[0] = data_hit && (fct0_r.link ? addr_hit[1] : 1'b1);
            end else begin
                event_now[0] = addr_hit[0];
            end
        end
        // comparator one compares addresses only
        if (watch_i.valid && (func1_r != 4'h0)) begin
            event_now[1] = addr_hit[1];
        end
    end

    // ------------------------------------------------------------
    // match flags: set wins over the read clear
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            flag_r <= '0;
        end else begin
            if (event_now[0]) begin
                flag_r[0] <= 1'b1;
            end else if (rd_take && (wb_adr_i == OFS_FCT0)) begin
                flag_r[0] <= 1'b0;
            end
            if (event_now[1]) begin
                flag_r[1] <= 1'b1;
            end else if (rd_take && (wb_adr_i == OFS_FCT1)) begin
                flag_r[1] <= 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            match_o <= '0;
        end else begin
            match_o <= event_now;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking dwp_cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    sequence s_read_of(logic [ADR_W-1:0] ofs);
        rd_take && (wb_adr_i == ofs);
    endsequence

    sequence s_write_of(logic [ADR_W-1:0] ofs);
        wr_take && (wb_adr_i == ofs);
    endsequence

    a_cap_read_value: assert property (
        s_read_of(OFS_CAP) |=> wb_ack_o && (wb_dat_o == 32'h2F00_0000))
        else $error("capability read returned wrong value");

    a_cap_flags_set: assert property (
        s_read_of(OFS_CAP) |=> (wb_dat_o[27:24] == 4'hF))
        else $error("capability bits 27..24 not all one");

    a_cap_low_zero: assert property (
        s_read_of(OFS_CAP) |=> (wb_dat_o[22:0] == 23'h0) && !wb_dat_o[23])
        else $error("capability low bits not zero");

    a_mask_sat_value: assert property (
        s_write_of(OFS_MASK1) ##0 wb_sel_i[0] ##0 (wb_dat_i[4:0] > 5'h18)
        |=> (mask_r[1] == 5'h18))
        else $error("mask count did not saturate at 24");

    a_mask_upper_zero: assert property (
        s_read_of(OFS_MASK0) |=> (wb_dat_o[31:5] == 27'h0) && (wb_dat_o[4:0] <= 5'h18))
        else $error("mask read has upper bits set or exceeds 24");

    a_flag_on_match: assert property (
        event_now[0] |=> flag_r[0] && match_o[0])
        else $error("match event did not set flag and pulse");

    a_flag_read_clear: assert property (
        s_read_of(OFS_FCT0) ##0 !event_now[0]
        |=> wb_ack_o && !flag_r[0] ##1 !wb_ack_o)
        else $error("function read did not clear match flag");

    a_flag_holds_read: assert property (
        s_read_of(OFS_FCT0) ##0 flag_r[0] |=> wb_dat_o[24])
        else $error("set match flag not seen on read");

    a_comp1_addr_only: assert property (
        watch_i.valid && (func1_r != 4'h0) && !addr_hit[1] |=> !match_o[1])
        else $error("comparator one matched without address hit");

    a_cap_write_none: assert property (
        s_write_of(OFS_CAP) |-> ##1 $stable(comp_r[0]) && $stable(mask_r[0])
        && $stable(fct0_r))
        else $error("write to capability changed other state");

endmodule // dwp_top

// ===== tb/dwp_core_model.sv
// behavioural model of the watched core bus
`timescale 1ns/10ps
module dwp_core_model
    import dwp_pkg::*;
(
    // clock
    input wire logic ref_clk,
    // observed transfer
    output dwp_watch_s watch_o
);

initial begin
    watch_o = '0;
end

// one transfer for one cycle, then released fetch, address and data lines carry inverted junk
task automatic send(input logic f, input dwp_size_e s, input logic [31:0] a,
        input logic [31:0] d);
    @(posedge ref_clk);
    watch_o <= '{valid: 1'b1, fetch: f, size: s, addr: a, data: d};
    @(posedge ref_clk);
    watch_o <= '{valid: 1'b0, fetch: ~f, size: s, addr: ~a, data: ~d};
endtask

endmodule // dwp_core_model

// ===== tb/tb_dwp_top.sv
// self-checking bench for the dual watchpoint comparator
`timescale 1ns/10ps
module tb_dwp_top
    import dwp_pkg::*;
;

logic ref_clk = 1'b0;
logic rst_n = 1'b0;
logic wb_cyc_i = 1'b0;
logic wb_stb_i = 1'b0;
logic wb_we_i = 1'b0;
logic [11:0] wb_adr_i = 12'h000;
logic [3:0] wb_sel_i = 4'h0;
logic [31:0] wb_dat_i = 32'h0000_0000;
logic [31:0] wb_dat_o;
logic wb_ack_o;
logic [1:0] match_o;
dwp_watch_s watch_i;
int err_count = 0;
int num_checks = 0;
logic [31:0] rd;

initial begin
    forever #5 ref_clk = ~ref_clk;
end

dwp_top #(.ADR_W(12), .NUM_CMP(2)) uut (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o),
    .watch_i(watch_i),
    .match_o(match_o)
);

dwp_core_model core (
    .ref_clk(ref_clk),
    .watch_o(watch_i)
);

task automatic give_verdict();
    if (err_count == 0 && num_checks > 0) begin
        $display("== PASSED ==");
    end else begin
        $display("== FAILED ==");
    end
    $finish;
endtask

task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
        err_count++;
        $display("[ERR] %0t reg got %08h exp %08h", $time, got, exp);
    end
endtask

task automatic chk_match(input logic [1:0] got, input logic [1:0] exp);
    num_checks++;
    if (got !== exp) begin
        err_count++;
        $display("[ERR] %0t match got %01h exp %01h", $time, got, exp);
    end
endtask

// one classic cycle, held until ack is sampled
task automatic wb_xfer(input logic we, input logic [11:0] adr, input logic [31:0] dat,
        input logic [3:0] sel, output logic [31:0] q);
    int n;
    @(posedge ref_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    wb_sel_i <= sel;
    for (n = 0; n < 20; n++) begin
        @(posedge ref_clk);
        if (wb_ack_o === 1'b1) break;
    end
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    if (n == 20) begin
        err_count++;
        give_verdict();
    end
    @(posedge ref_clk);
endtask

task automatic wr(input logic [11:0] adr, input logic [31:0] dat);
    wb_xfer(1'b1, adr, dat, 4'hF, rd);
endtask

task automatic rd_chk(input logic [11:0] adr, input logic [31:0] exp);
    wb_xfer(1'b0, adr, 32'h0000_0000, 4'hF, rd);
    chk_reg(rd, exp);
endtask

task automatic watch_chk(input logic f, input dwp_size_e s, input logic [31:0] a,
        input logic [31:0] d, input logic [1:0] exp);
    core.send(f, s, a, d);
    #1;
    chk_match(match_o, exp);
endtask

task automatic t_reset_cap();
    rd_chk(12'h000, 32'h2F00_0000);
    wr(12'h000, 32'h0000_0000);
    rd_chk(12'h000, 32'h2F00_0000);
    rd_chk(12'h020, 32'h0000_0000);
    rd_chk(12'h024, 32'h0000_0000);
    rd_chk(12'h028, 32'h0000_0000);
    rd_chk(12'h100, 32'h0000_0000);
endtask

task automatic t_regs();
    wr(12'h020, 32'hA5A5_0F0F);
    rd_chk(12'h020, 32'hA5A5_0F0F);
    wb_xfer(1'b1, 12'h020, 32'h1111_2222, 4'h5, rd);
    rd_chk(12'h020, 32'hA511_0F22);
    wr(12'h030, 32'h3000_0000);
    rd_chk(12'h030, 32'h3000_0000);
    wr(12'h024, 32'hFFFF_FFF5);
    rd_chk(12'h024, 32'h0000_0015);
    wb_xfer(1'b1, 12'h024, 32'h0000_0003, 4'hE, rd);
    rd_chk(12'h024, 32'h0000_0015);
    wr(12'h034, 32'h0000_001F);
    rd_chk(12'h034, 32'h0000_0018);
    wr(12'h034, 32'h0000_0019);
    rd_chk(12'h034, 32'h0000_0018);
    wr(12'h034, 32'h0000_0017);
    rd_chk(12'h034, 32'h0000_0017);
    wr(12'h034, 32'h0000_0000);
endtask

task automatic t_addr();
    wr(12'h020, 32'h2000_0010);
    wr(12'h024, 32'h0000_0000);
    wr(12'h028, 32'h0000_0001);
    watch_chk(1'b1, DWP_SIZE_HALF, 32'h2000_0011, 32'h0, 2'b01);
    watch_chk(1'b0, DWP_SIZE_HALF, 32'h2000_0011, 32'h0, 2'b00);
    wr(12'h024, 32'h0000_0004);
    watch_chk(1'b0, DWP_SIZE_WORD, 32'h2000_001F, 32'h0, 2'b01);
    watch_chk(1'b1, DWP_SIZE_WORD, 32'h2000_0020, 32'h0, 2'b00);
    wr(12'h038, 32'h0000_0001);
    watch_chk(1'b0, DWP_SIZE_WORD, 32'h3000_0000, 32'h0, 2'b10);
    rd_chk(12'h028, 32'h0100_0001);
    rd_chk(12'h028, 32'h0000_0001);
    wr(12'h028, 32'h0000_0000);
    watch_chk(1'b0, DWP_SIZE_WORD, 32'h2000_0010, 32'h0, 2'b00);
    rd_chk(12'h028, 32'h0000_0000);
endtask

task automatic t_data();
    logic [31:0] lane;
    wr(12'h024, 32'h0000_0000);
    wr(12'h020, 32'h5A5A_5A5A);
    wr(12'h038, 32'h0000_0000);
    for (int s = 0; s < 4; s++) begin
        lane = (s == 0) ? 32'h0000_005A : (s == 1) ? 32'h0000_5A5A : 32'h5A5A_5A5A;
        wr(12'h028, 32'h0000_0101 | (32'(s) << 10));
        watch_chk(1'b0, dwp_size_e'(s), 32'h4000_0000, lane, (s == 3) ? 2'b00 : 2'b01);
    end
    rd_chk(12'h028, 32'h0100_0D01);
    wr(12'h028, 32'h0000_0901);
    watch_chk(1'b0, DWP_SIZE_WORD, 32'h4000_0000, 32'h5A5A_5A5B, 2'b00);
    watch_chk(1'b0, DWP_SIZE_BYTE, 32'h4000_0000, 32'h5A5A_5A5A, 2'b00);
    wr(12'h038, 32'h0000_0101);
    rd_chk(12'h038, 32'h0100_0001);
    rd_chk(12'h038, 32'h0000_0001);
    wr(12'h038, 32'h0000_0000);
    wr(12'h028, 32'h0000_F901);
    rd_chk(12'h028, 32'h0000_1901);
    watch_chk(1'b0, DWP_SIZE_WORD, 32'h3000_0000, 32'h5A5A_5A5A, 2'b01);
    watch_chk(1'b0, DWP_SIZE_WORD, 32'h3000_0040, 32'h5A5A_5A5A, 2'b00);
endtask

initial begin
    repeat (20) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_reset_cap();
    t_regs();
    t_addr();
    t_data();
    give_verdict();
end

endmodule // tb_dwp_top
